// ==== inc/core_irq_pkg.sv ====
// constants and types shared by the core interrupt controller
`default_nettype none
package core_irq_pkg;
  // register indices; byte address is four times the index
  localparam int ADDR_W = 15;
  localparam int IDX_W = 13;
  localparam logic [IDX_W-1:0] IDX_INTCTL = 13'h000B;
  localparam logic [IDX_W-1:0] IDX_FIRST_PERIPHERAL_ENABLE_REG = 13'h0096;
  localparam logic [IDX_W-1:0] IDX_PIR0 = 13'h008C;
  localparam logic [IDX_W-1:0] IDX_SHADOW0 = 13'h1FE4;
  localparam int SHADOW_COUNT = 8;
  // shadow slots
  localparam int SH_WORKING_REGISTER = 0;
  localparam int SH_STATUS = 1;
  localparam int SH_BSR = 2;
  localparam int SH_PC_HIGH_LATCH = 3;
  localparam int SH_FSR0L = 4;
  // interrupt_control fields
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
  localparam int EDGE_BIT = 0;
  localparam logic [7:0] INTCTL_RST = 8'h01;
  localparam logic [7:0] INTCTL_MASK = 8'hC1;
  // first peripheral enable/request fields
  localparam int TMR0_BIT = 5;
  localparam int IOC_BIT = 4;
  localparam int EXT_BIT = 0;
  localparam logic [7:0] FIRST_PERIPHERAL_ENABLE_REG_MASK = 8'h31;
  localparam logic [7:0] REG_RST = 8'h00;
  // status bits that are not shadowed: timeout (4), power-down (3)
  localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;
  localparam logic [15:0] VECTOR_ADDR = 16'h0004;
  localparam int QUARTERS = 4;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_AFTER_SLEEP = 4'b0010,
    ST_FLUSH = 4'b0100,
    ST_VECTOR = 4'b1000
  } irq_state_e;
endpackage
`default_nettype wire

// ==== hdl/core_interrupt_controller.sv ====
// interrupt controller: flags, enables, external pin, vectoring and context shadowing
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_controller #(
  parameter int REG_GROUPS = 7,
  parameter int QUARTER_DIV = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [core_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [REG_GROUPS*8-1:0] periph_event,
  input wire logic ext_int_pin,
  input wire logic core_sleep,
  input wire logic return_from_interrupt_instr_exec,
  input wire logic [7:0] working_register_live,
  input wire logic [7:0] status_live,
  input wire logic [7:0] bsr_live,
  input wire logic [7:0] pc_high_latch_live,
  input wire logic [31:0] fsr_live,
  output logic q1_strobe,
  output logic irq_flush,
  output logic irq_vector,
  output logic [15:0] vector_addr,
  output logic wake_req,
  output logic global_irq_enable,
  output logic ctx_restore,
  output logic [7:0] working_register_restore,
  output logic [7:0] status_restore,
  output logic [7:0] bsr_restore,
  output logic [7:0] pc_high_latch_restore,
  output logic [31:0] fsr_restore
);
  import core_irq_pkg::*;

  localparam int DIV_W = $clog2(QUARTER_DIV) + 1;

  generate
    if (REG_GROUPS < 1 || REG_GROUPS > 8 || QUARTER_DIV < 1) begin : g_bad_param
      $error("core_interrupt_controller: unsupported parameter values");
    end
  endgenerate

  function automatic logic in_range(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] base,
                                    input int count);
    in_range = (idx >= base) && ({19'h0, idx} < {19'h0, base} + count);
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // instruction cycle phases
  logic [DIV_W-1:0] div_q;
  logic [1:0] phase_q;
  logic quarter_en;
  logic q1_en;

  assign quarter_en = (div_q == DIV_W'(QUARTER_DIV - 1));
  assign q1_en = quarter_en && (phase_q == 2'd0);
  assign q1_strobe = q1_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      phase_q <= 2'd0;
    end else if (quarter_en) begin
      div_q <= '0;
      phase_q <= 2'(phase_q + 2'd1);
    end else begin
      div_q <= DIV_W'(div_q + 1'b1);
    end
  end

  // external pin synchroniser
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic ext_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_int_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  logic [7:0] intctl_q;
  logic gie_q, peripheral_group_enable_q, edge_sel;
  assign gie_q = intctl_q[GIE_BIT];
  assign peripheral_group_enable_q = intctl_q[PERIPHERAL_GROUP_ENABLE_BIT];
  assign edge_sel = intctl_q[EDGE_BIT];
  assign global_irq_enable = gie_q;

  assign ext_edge = edge_sel ? (ext_s2_q && !ext_s3_q) : (!ext_s2_q && ext_s3_q);

  // bus decode
  logic [IDX_W-1:0] idx;
  logic aligned, hit_ctl, hit_pie, hit_pir, hit_sh, hit_any;
  logic wr_en, setup;
  logic [IDX_W-1:0] pie_sel, pir_sel, sh_sel;

  assign idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign hit_ctl = aligned && (idx == IDX_INTCTL);
  assign hit_pie = aligned && in_range(idx, IDX_FIRST_PERIPHERAL_ENABLE_REG, REG_GROUPS);
  assign hit_pir = aligned && in_range(idx, IDX_PIR0, REG_GROUPS);
  assign hit_sh = aligned && in_range(idx, IDX_SHADOW0, SHADOW_COUNT);
  assign hit_any = hit_ctl || hit_pie || hit_pir || hit_sh;
  assign pie_sel = IDX_W'(idx - IDX_FIRST_PERIPHERAL_ENABLE_REG);
  assign pir_sel = IDX_W'(idx - IDX_PIR0);
  assign sh_sel = IDX_W'(idx - IDX_SHADOW0);
  assign wr_en = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign pready = 1'b1;

  // sequencing state
  irq_state_e st_q;
  logic any_pending;
  logic detect;

  assign detect = q1_en && (st_q == ST_IDLE) && gie_q && any_pending;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intctl_q <= INTCTL_RST;
    end else begin
      if (wr_en && hit_ctl) begin
        intctl_q <= pwdata[7:0] & INTCTL_MASK;
      end
      // entry clears global enable, also on the post-sleep path
      if ((detect || (st_q == ST_AFTER_SLEEP && q1_en)) && !core_sleep) begin
        intctl_q[GIE_BIT] <= 1'b0;
      end
      if (return_from_interrupt_instr_exec) begin
        intctl_q[GIE_BIT] <= 1'b1;
      end
    end
  end

  logic [7:0] pie_q [REG_GROUPS];
  logic [7:0] pir_q [REG_GROUPS];
  logic [REG_GROUPS-1:0] grp_pend;

  generate
    for (genvar g = 0; g < REG_GROUPS; g++) begin : g_grp
      logic [7:0] ev;
      logic [7:0] wmask;
      // pin edge feeds the external flag
      assign ev = periph_event[g*8 +: 8] | ((g == 0) ? (8'(ext_edge) << EXT_BIT) : 8'h00);
      // only documented enable bits of group zero exist
      assign wmask = (g == 0) ? FIRST_PERIPHERAL_ENABLE_REG_MASK : 8'hFF;
      assign grp_pend[g] = (|(pir_q[g] & pie_q[g])) && ((g == 0) || peripheral_group_enable_q);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pie_q[g] <= REG_RST;
        end else if (wr_en && hit_pie && pie_sel == IDX_W'(g)) begin
          pie_q[g] <= pwdata[7:0] & wmask;
        end
      end

      // flags set regardless of enables; set wins over clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pir_q[g] <= REG_RST;
        end else if (wr_en && hit_pir && pir_sel == IDX_W'(g)) begin
          pir_q[g] <= pwdata[7:0] | ev;
        end else begin
          pir_q[g] <= pir_q[g] | ev;
        end
      end
    end
  endgenerate

  assign any_pending = |grp_pend;
  assign wake_req = core_sleep && any_pending;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (detect) begin
            st_q <= core_sleep ? ST_AFTER_SLEEP : ST_FLUSH;
          end
        end
        ST_AFTER_SLEEP: begin
          // let the post-sleep instruction run first
          if (q1_en && !core_sleep) begin
            st_q <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          if (q1_en) begin
            st_q <= ST_VECTOR;
          end
        end
        ST_VECTOR: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign irq_flush = (st_q == ST_FLUSH);
  assign irq_vector = (st_q == ST_VECTOR);
  assign vector_addr = VECTOR_ADDR;

  logic [7:0] shadow_q [SHADOW_COUNT];
  logic [7:0] live [SHADOW_COUNT];
  assign live[SH_WORKING_REGISTER] = working_register_live;
  assign live[SH_STATUS] = status_live & STATUS_SAVE_MASK;
  assign live[SH_BSR] = bsr_live;
  assign live[SH_PC_HIGH_LATCH] = pc_high_latch_live;

  generate
    for (genvar s = 0; s < SHADOW_COUNT; s++) begin : g_sh
      if (s >= SH_FSR0L) begin : g_fsr
        assign live[s] = fsr_live[(s - SH_FSR0L)*8 +: 8];
        assign fsr_restore[(s - SH_FSR0L)*8 +: 8] = shadow_q[s];
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shadow_q[s] <= REG_RST;
        end else if (irq_vector) begin
          shadow_q[s] <= live[s];
        end else if (wr_en && hit_sh && sh_sel == IDX_W'(s)) begin
          shadow_q[s] <= (s == SH_STATUS) ? (pwdata[7:0] & STATUS_SAVE_MASK) : pwdata[7:0];
        end
      end
    end
  endgenerate

  assign working_register_restore = shadow_q[SH_WORKING_REGISTER];
  assign status_restore = shadow_q[SH_STATUS];
  assign bsr_restore = shadow_q[SH_BSR];
  assign pc_high_latch_restore = shadow_q[SH_PC_HIGH_LATCH];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_restore <= 1'b0;
    end else begin
      ctx_restore <= return_from_interrupt_instr_exec;
    end
  end

  // read data captured in setup phase
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit_ctl) begin
      rd_mux = intctl_q;
    end else if (hit_pie) begin
      rd_mux = pie_q[pie_sel[2:0]];
    end else if (hit_pir) begin
      rd_mux = pir_q[pir_sel[2:0]];
    end else if (hit_sh) begin
      rd_mux = shadow_q[sh_sel[2:0]];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= {24'h00_0000, rd_mux};
      pslverr <= !hit_any;
    end
  end

  sequence s_detect;
    detect && !core_sleep;
  endsequence

  sequence s_sleep_detect;
    detect && core_sleep;
  endsequence

  chk_no_vec_gie_off: assert property ($rose(st_q == ST_FLUSH) && $past(st_q) == ST_IDLE |-> $past(gie_q))
    else $error("flush entered with global enable clear");
  chk_group_gate: assert property (q1_en && st_q == ST_IDLE && !any_pending |=> st_q == ST_IDLE)
    else $error("vectoring without an enabled pending source");
  chk_ext_flag_set: assert property (ext_edge |=> pir_q[0][EXT_BIT])
    else $error("external flag not set after edge");
  chk_entry_steps: assert property (s_detect |=> irq_flush && !gie_q)
    else $error("entry did not flush and clear global enable");
  chk_vector_latency: assert property (s_detect |-> ##[5:64] irq_vector)
    else $error("vector not reached in time");
  chk_return_steps: assert property (return_from_interrupt_instr_exec |=> gie_q && ctx_restore)
    else $error("return did not restore and enable");
  chk_q1_sample: assert property ($rose(st_q == ST_FLUSH) && $past(st_q) == ST_IDLE |-> $past(q1_en))
    else $error("request taken outside first quarter");
  chk_wake_req: assert property (core_sleep && any_pending |-> wake_req)
    else $error("no wake on pending request");
  chk_sleep_defer: assert property (s_sleep_detect |=> st_q == ST_AFTER_SLEEP)
    else $error("branch not deferred after sleep");
  chk_edge_select: assert property (ext_edge |-> ext_s2_q == edge_sel)
    else $error("wrong edge polarity");
  chk_shadow_save: assert property (irq_vector |=> working_register_restore == $past(working_register_live))
    else $error("working register not shadowed");
  chk_status_mask: assert property ((status_restore & ~STATUS_SAVE_MASK) == 8'h00)
    else $error("timeout or power-down bit shadowed");

endmodule // core_interrupt_controller
`default_nettype wire

// ==== dv/core_side_model.sv ====
// core-side partner: live context, snapshot at vector, delayed return
`timescale 1ns/1ns
`default_nettype none
module core_side_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_vector,
  input wire logic isr_done,
  input wire logic [2:0] ret_delay,
  output logic return_from_interrupt_instr_exec,
  output logic [31:0] ctx_live,
  output logic [31:0] ctx_saved,
  output logic [31:0] fsr_live,
  output logic [31:0] fsr_saved
);
  logic [31:0] lfsr_q;
  logic [3:0] wait_q;
  assign ctx_live = lfsr_q;
  assign fsr_live = ~{lfsr_q[15:0], lfsr_q[31:16]};
  // context moves every cycle so a stale capture shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q <= 32'h1234ABCD;
      ctx_saved <= '0;
      fsr_saved <= '0;
    end else begin
      lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      if (irq_vector) begin
        ctx_saved <= ctx_live;
        fsr_saved <= fsr_live;
      end
    end
  end
  // return issued a chosen number of cycles after service ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= '0;
      return_from_interrupt_instr_exec <= 1'b0;
    end else begin
      return_from_interrupt_instr_exec <= (wait_q == 4'h1);
      if (isr_done) begin
        wait_q <= {1'b0, ret_delay} + 4'h1;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule // core_side_model
`default_nettype wire

// ==== dv/core_interrupt_controller_tb.sv ====
// self-checking bench for the core interrupt controller
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_controller_tb;
  import core_irq_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [55:0] periph_event = '0;
  logic ext_int_pin = 1'b0;
  logic core_sleep = 1'b0;
  logic isr_done = 1'b0;
  logic [2:0] ret_delay = 3'h0;
  logic [31:0] prdata, fsr_live, fsr_restore, fsr_saved, ctx_live, ctx_saved;
  logic pready, pslverr, return_from_interrupt_instr_exec, q1_strobe, irq_flush, irq_vector, wake_req, global_irq_enable, ctx_restore;
  logic [7:0] working_register_restore, status_restore, bsr_restore, pc_high_latch_restore, rd, v;
  logic [15:0] vector_addr;
  logic err;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 86;
  int lat, g, b;

  core_interrupt_controller #(.REG_GROUPS(7), .QUARTER_DIV(1)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_event(periph_event),
    .ext_int_pin(ext_int_pin), .core_sleep(core_sleep), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec),
    .working_register_live(ctx_live[7:0]), .status_live(ctx_live[15:8]), .bsr_live(ctx_live[23:16]),
    .pc_high_latch_live(ctx_live[31:24]), .fsr_live(fsr_live), .q1_strobe(q1_strobe), .irq_flush(irq_flush),
    .irq_vector(irq_vector), .vector_addr(vector_addr), .wake_req(wake_req),
    .global_irq_enable(global_irq_enable), .ctx_restore(ctx_restore), .working_register_restore(working_register_restore),
    .status_restore(status_restore), .bsr_restore(bsr_restore), .pc_high_latch_restore(pc_high_latch_restore),
    .fsr_restore(fsr_restore));

  core_side_model i_core (
    .pclk(pclk), .presetn(presetn), .irq_vector(irq_vector), .isr_done(isr_done), .ret_delay(ret_delay),
    .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec), .ctx_live(ctx_live), .ctx_saved(ctx_saved), .fsr_live(fsr_live),
    .fsr_saved(fsr_saved));

  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // enable register readback: first register keeps only its three bits
  function automatic logic [7:0] exp_en(input int grp, input logic [7:0] val);
    return (grp == 0) ? (val & FIRST_PERIPHERAL_ENABLE_REG_MASK) : val;
  endfunction

  task automatic apb(input logic wr, input int idx, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {IDX_W'(idx), 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge: next setup never reassigns in this time step
    @(posedge pclk);
  endtask

  task automatic rchk(input string name, input int idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(name, exp, rd);
  endtask

  task automatic ev(input int bitn);
    periph_event <= 56'h1 << bitn;
    @(posedge pclk);
    periph_event <= '0;
  endtask

  task automatic wait_vec(input int lim);
    lat = 0;
    while (irq_vector !== 1'b1 && lat <= lim) begin
      @(posedge pclk);
      lat++;
    end
    check("vector_in_time", 1, lat <= lim);
    check("vector_addr", VECTOR_ADDR, vector_addr);
  endtask

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge pclk);
      if (irq_vector === 1'b1 || irq_flush === 1'b1) seen = 1'b1;
    end
    check("no_vector", 0, seen);
  endtask

  task automatic service();
    logic [7:0] wnew;
    wnew = 8'($random(seed));
    for (int k = 0; k < 7; k++) apb(1'b1, IDX_PIR0 + k, 8'h00);
    apb(1'b1, IDX_SHADOW0 + SH_WORKING_REGISTER, wnew);
    rchk("shadow_rw", IDX_SHADOW0 + SH_WORKING_REGISTER, wnew);
    isr_done <= 1'b1;
    ret_delay <= 3'($random(seed));
    @(posedge pclk);
    isr_done <= 1'b0;
    lat = 0;
    while (ctx_restore !== 1'b1 && lat < 20) begin
      @(posedge pclk);
      lat++;
    end
    check("restore_in_time", 1, lat < 20);
    check("gie_return", 1, global_irq_enable);
    check("working_register_restore", wnew, working_register_restore);
    check("status_restore", ctx_saved[15:8] & STATUS_SAVE_MASK, status_restore);
    check("bsr_restore", ctx_saved[23:16], bsr_restore);
    check("pc_high_latch_restore", ctx_saved[31:24], pc_high_latch_restore);
    check("fsr_restore", fsr_saved, fsr_restore);
    quiet(12);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("gie_reset", 0, global_irq_enable);
    rchk("intctl_reset", IDX_INTCTL, INTCTL_RST);
    apb(1'b0, 13'h0001, 8'h00);
    check("unmapped_err", 1, err);
    for (int k = 0; k < 7; k++) begin
      v = 8'($random(seed));
      rchk("enable_reset", IDX_FIRST_PERIPHERAL_ENABLE_REG + k, REG_RST);
      apb(1'b1, IDX_FIRST_PERIPHERAL_ENABLE_REG + k, v);
      rchk("enable_rw", IDX_FIRST_PERIPHERAL_ENABLE_REG + k, exp_en(k, v));
      apb(1'b1, IDX_FIRST_PERIPHERAL_ENABLE_REG + k, 8'h00);
    end
    v = 8'($random(seed)) & 8'h7F;
    apb(1'b1, IDX_INTCTL, v);
    rchk("intctl_rw", IDX_INTCTL, v & INTCTL_MASK);
    // group source: flag while disabled, held off by group enable
    g = 1 + ({$random(seed)} % 6);
    b = {$random(seed)} % 8;
    apb(1'b1, IDX_INTCTL, 8'h01);
    ev(g * 8 + b);
    rchk("flag_poll", IDX_PIR0 + g, 8'h01 << b);
    apb(1'b1, IDX_FIRST_PERIPHERAL_ENABLE_REG + g, 8'h01 << b);
    apb(1'b1, IDX_INTCTL, 8'h81);
    quiet(24);
    apb(1'b1, IDX_INTCTL, 8'hC1);
    wait_vec(16);
    check("gie_cleared", 0, global_irq_enable);
    service();
    apb(1'b1, IDX_FIRST_PERIPHERAL_ENABLE_REG + g, 8'h00);
    // first-register source needs no group enable
    apb(1'b1, IDX_INTCTL, 8'h81);
    apb(1'b1, IDX_FIRST_PERIPHERAL_ENABLE_REG, 8'h01 << TMR0_BIT);
    ev(TMR0_BIT);
    wait_vec(16);
    service();
    // external pin, rising then falling
    apb(1'b1, IDX_FIRST_PERIPHERAL_ENABLE_REG, 8'h01 << EXT_BIT);
    for (int e = 1; e >= 0; e--) begin
      apb(1'b1, IDX_INTCTL, 8'h80 | 8'(e));
      ext_int_pin <= e[0];
      wait_vec(20);
      rchk("ext_flag", IDX_PIR0, 8'h01 << EXT_BIT);
      service();
    end
    apb(1'b1, IDX_FIRST_PERIPHERAL_ENABLE_REG, 8'h01 << TMR0_BIT);
    apb(1'b1, IDX_INTCTL, 8'h01);
    core_sleep <= 1'b1;
    ev(TMR0_BIT);
    @(posedge pclk);
    check("wake_no_gie", 1, wake_req);
    quiet(12);
    apb(1'b1, IDX_PIR0, 8'h00);
    check("wake_cleared", 0, wake_req);
    apb(1'b1, IDX_INTCTL, 8'h81);
    ev(TMR0_BIT);
    quiet(12);
    core_sleep <= 1'b0;
    wait_vec(24);
    check("gie_cleared_sleep", 0, global_irq_enable);
    service();
    // reset in mid-run disables everything again
    apb(1'b1, IDX_INTCTL, 8'hC1);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("gie_rereset", 0, global_irq_enable);
    rchk("intctl_rereset", IDX_INTCTL, INTCTL_RST);
    complete_run();
  end
endmodule // core_interrupt_controller_tb
`default_nettype wire
